// ==== pkg/gie_pkg.sv ====
// constants shared by the grouped interrupt expander
package gie_pkg;
   localparam int GIE_NGRP = 12;
   localparam int GIE_NENT = 8;
   localparam int GIE_NREQ = 96;
   // register word addresses
   localparam logic [15:0] GIE_CTRL_ADDR = 16'h0ce0;
   localparam logic [15:0] GIE_ACK_ADDR = 16'h0ce1;
   localparam logic [15:0] GIE_GRP_BASE = 16'h0ce2;
   localparam logic [15:0] GIE_GRP_LAST = 16'h0cf9;
   localparam logic [15:0] GIE_VEC_BASE = 16'h0d40;
   localparam logic [15:0] GIE_VEC_LAST = 16'h0dff;
   // control field and reset values
   localparam int GIE_CTRL_EN_BIT = 0;
   localparam logic [15:0] GIE_CTRL_RST = 16'h0000;
   localparam logic [11:0] GIE_ACK_RST = 12'h000;
   localparam logic [7:0] GIE_GRP_RST = 8'h00;
   // group index of each source family (zero based)
   localparam logic [3:0] GIE_GRP_ADC_EXT = 4'h0;
   localparam logic [3:0] GIE_GRP_PWM_TRIP = 4'h1;
   localparam logic [3:0] GIE_GRP_PWM_EVT = 4'h2;
   localparam logic [3:0] GIE_GRP_DMA = 4'h6;
   localparam logic [3:0] GIE_GRP_ACCEL = 4'ha;
   typedef enum logic [1:0] {GIE_FETCH_INT, GIE_FETCH_TRAP} gie_fetch_t;
endpackage

// ==== pkg/gie_grp_if.sv ====
// signals between the expander core and one group slice
`timescale 1ns/10ps
interface gie_grp_if;
   logic [7:0] req_set;
   logic en_we;
   logic fl_we;
   logic [7:0] wdata;
   logic clr;
   logic [7:0] en;
   logic [7:0] flag;
   logic pend;
   logic [2:0] pidx;
   modport grp (input req_set, en_we, fl_we, wdata, clr, output en, flag, pend, pidx);
   modport ctl (output req_set, en_we, fl_we, wdata, clr, input en, flag, pend, pidx);
endinterface

// ==== hdl/gie_group.sv ====
// one group of eight flagged, enabled requests
`timescale 1ns/10ps
module gie_group
   import gie_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // core side
   gie_grp_if.grp g
);
   logic [7:0] en_r;
   logic [7:0] flag_r;
   logic [7:0] flag_nxt;
   logic [7:0] live;
   logic [7:0] clr_mask;

   assign live = flag_r & en_r;
   assign clr_mask = g.clr ? (8'h01 << g.pidx) : 8'h00;
   // a write replaces all bits; a same-cycle set still wins so no edge is lost
   assign flag_nxt = (g.fl_we ? g.wdata : (flag_r & ~clr_mask)) | g.req_set;

   // lowest entry wins
   always_comb begin
      g.pidx = 3'h0;
      for (int i = GIE_NENT - 1; i >= 0; i--) begin
         if (live[i]) begin
            g.pidx = 3'(i);
         end
      end
   end

   assign g.pend = |live;
   assign g.en = en_r;
   assign g.flag = flag_r;

   // enable and flag registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         en_r <= GIE_GRP_RST;
         flag_r <= GIE_GRP_RST;
      end else begin
         if (g.en_we) begin
            en_r <= g.wdata;
         end
         flag_r <= flag_nxt;
      end
   end
endmodule // gie_group

// ==== hdl/gie_top.sv ====
// grouped interrupt expander: registers, vector table, cpu lines
`timescale 1ns/10ps
module gie_top
   import gie_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // peripheral requests, bit g*8+e is group g+1 entry e+1
   input wire logic [95:0] req_in,
   // processor register port, 16-bit words
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   input wire logic protected_write_unlock,
   output logic [15:0] rd_data,
   output logic rd_valid,
   // cpu interrupt lines
   output logic [11:0] cpu_int,
   // vector fetch port
   input wire logic fetch_req,
   input wire logic fetch_trap,
   input wire logic [3:0] fetch_num,
   output logic [31:0] fetch_vec,
   output logic fetch_valid,
   output logic fetch_bad
);
   gie_grp_if gif[GIE_NGRP] ();

   logic [95:0] req_s1_r;
   logic [95:0] req_s2_r;
   logic [95:0] req_s3_r;
   logic [95:0] req_rise;
   logic [15:0] ctrl_r;
   logic [11:0] ack_r;
   logic [11:0] ack_nxt;
   logic [11:0] pend;
   logic [11:0] clr_grp;
   logic [2:0] pidx_a [GIE_NGRP];
   logic [7:0] en_a [GIE_NGRP];
   logic [7:0] flag_a [GIE_NGRP];
   logic [31:0] vec_mem [GIE_NREQ];
   logic [15:0] rd_data_r;
   logic rd_valid_r;
   logic [11:0] cpu_int_r;
   logic [31:0] fetch_vec_r;
   logic fetch_valid_r;
   logic fetch_bad_r;
   logic [15:0] rd_nxt;

   // address decode
   wire en_on = ctrl_r[GIE_CTRL_EN_BIT];
   wire is_ctrl = (reg_addr == GIE_CTRL_ADDR);
   wire is_ack = (reg_addr == GIE_ACK_ADDR);
   wire is_grp = (reg_addr >= GIE_GRP_BASE) && (reg_addr <= GIE_GRP_LAST);
   wire is_vec = (reg_addr >= GIE_VEC_BASE) && (reg_addr <= GIE_VEC_LAST);
   wire [15:0] grp_off = reg_addr - GIE_GRP_BASE;
   wire [3:0] grp_sel = grp_off[4:1];
   wire grp_is_flag = grp_off[0]; // even word enable, odd word flag
   wire [15:0] vec_off = reg_addr - GIE_VEC_BASE;
   wire [6:0] vec_ent = vec_off[7:1];
   wire vec_hi = vec_off[0]; // low word first within an entry
   // table stays locked unless the unlock is held
   wire vec_we = reg_wr && is_vec && protected_write_unlock;
   wire ctl_we = reg_wr && (is_ctrl || is_ack || is_grp);

   // fetch decode: number 1..12 names a group
   wire [3:0] f_grp = fetch_num - 4'h1;
   wire f_in_range = (fetch_num != 4'h0) && (fetch_num <= 4'(GIE_NGRP));
   // number zero would want a reset vector, which this table never has
   wire f_ok_trap = fetch_trap && f_in_range && en_on;
   wire f_ok_int = !fetch_trap && f_in_range && en_on && pend[f_grp];
   wire [6:0] f_ent = fetch_trap ? {f_grp[3:0], 3'h0} : {f_grp[3:0], pidx_a[f_grp]};
   wire f_take_int = fetch_req && f_ok_int;

   // request synchroniser, edge seen after the second stage only
   assign req_rise = req_s2_r & ~req_s3_r;

   // per-group slices, the position decides the source family
   for (genvar gi = 0; gi < GIE_NGRP; gi++) begin : g_grp
      assign gif[gi].req_set = req_rise[gi * 8 +: 8];
      assign gif[gi].en_we = reg_wr && is_grp && (grp_sel == 4'(gi)) && !grp_is_flag;
      assign gif[gi].fl_we = reg_wr && is_grp && (grp_sel == 4'(gi)) && grp_is_flag;
      assign gif[gi].wdata = reg_wdata[7:0];
      assign gif[gi].clr = clr_grp[gi];
      assign pend[gi] = gif[gi].pend;
      assign pidx_a[gi] = gif[gi].pidx;
      assign en_a[gi] = gif[gi].en;
      assign flag_a[gi] = gif[gi].flag;
      assign clr_grp[gi] = f_take_int && (f_grp == 4'(gi));
      gie_group u_grp (
         .clk(clk),
         .rst(rst),
         .g(gif[gi])
      );
   end

   // ack: set by a delivered interrupt vector (a trap fetch leaves it alone), a written one clears; the set wins
   assign ack_nxt = (ack_r & ~((reg_wr && is_ack) ? reg_wdata[11:0] : 12'h000)) | clr_grp;

   // read mux
   always_comb begin
      rd_nxt = 16'h0000;
      if (is_ctrl) begin
         rd_nxt = ctrl_r;
      end else if (is_ack) begin
         rd_nxt = {4'h0, ack_r};
      end else if (is_grp) begin
         rd_nxt = {8'h00, grp_is_flag ? flag_a[grp_sel] : en_a[grp_sel]};
      end else if (is_vec) begin
         rd_nxt = vec_hi ? vec_mem[vec_ent][31:16] : vec_mem[vec_ent][15:0];
      end
   end

   // synchroniser and register state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req_s1_r <= '0;
         req_s2_r <= '0;
         req_s3_r <= '0;
         ctrl_r <= GIE_CTRL_RST;
         ack_r <= GIE_ACK_RST;
      end else begin
         req_s1_r <= req_in;
         req_s2_r <= req_s1_r;
         req_s3_r <= req_s2_r;
         if (ctl_we && is_ctrl) begin
            ctrl_r <= reg_wdata & 16'h0001;
         end
         ack_r <= ack_nxt;
      end
   end

   // vector table has no reset; software fills it before enabling
   always_ff @(posedge clk) begin
      if (vec_we) begin
         if (vec_hi) begin
            vec_mem[vec_ent][31:16] <= reg_wdata;
         end else begin
            vec_mem[vec_ent][15:0] <= reg_wdata;
         end
      end
   end

   // registered outputs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_data_r <= 16'h0000;
         rd_valid_r <= 1'b0;
         cpu_int_r <= 12'h000;
         fetch_vec_r <= 32'h0000_0000;
         fetch_valid_r <= 1'b0;
         fetch_bad_r <= 1'b0;
      end else begin
         rd_valid_r <= reg_rd;
         if (reg_rd) begin
            rd_data_r <= rd_nxt;
         end
         // a line stays quiet while its group's acknowledge bit is set
         cpu_int_r <= en_on ? (pend & ~ack_r) : 12'h000;
         fetch_valid_r <= fetch_req;
         fetch_bad_r <= fetch_req && !(f_ok_trap || f_ok_int);
         if (fetch_req) begin
            fetch_vec_r <= (f_ok_trap || f_ok_int) ? vec_mem[f_ent] : 32'h0000_0000;
         end
      end
   end

   assign rd_data = rd_data_r;
   assign rd_valid = rd_valid_r;
   assign cpu_int = cpu_int_r;
   assign fetch_vec = fetch_vec_r;
   assign fetch_valid = fetch_valid_r;
   assign fetch_bad = fetch_bad_r;
endmodule // gie_top

// ==== verif/gie_cpu_model.sv ====
// processor-side model that issues vector fetches
`timescale 1ns/10ps
module gie_cpu_model
   import gie_pkg::*;
(
   // clock and known enable state
   input wire logic clk,
   input wire logic ctl_en,
   // fetch port
   output logic fetch_req,
   output logic fetch_trap,
   output logic [3:0] fetch_num,
   input wire logic [31:0] fetch_vec,
   input wire logic fetch_valid,
   input wire logic fetch_bad
);
   // idle port at time zero
   initial begin
      fetch_req = 1'b0;
      fetch_trap = 1'b0;
      fetch_num = 4'h5;
   end
   // one-cycle request; the answer is settled by the next falling edge
   task automatic fetch(input logic trap, input logic [3:0] num, output logic [31:0] vec, output logic bad);
      vec = 32'hx;
      bad = 1'bx;
      if (trap && num == 4'h0 && ctl_en) return; // a real core never does this
      @(negedge clk);
      fetch_req = 1'b1;
      fetch_trap = trap;
      fetch_num = num;
      @(negedge clk);
      fetch_req = 1'b0;
      fetch_num = ~num; // released field keeps moving
      vec = fetch_valid ? fetch_vec : 32'hx;
      bad = fetch_bad;
   endtask
endmodule // gie_cpu_model

// ==== verif/gie_sva.sv ====
// port-level assertions for the expander top
`timescale 1ns/10ps
module gie_sva
   import gie_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid,
   input wire logic fetch_req,
   input wire logic fetch_trap,
   input wire logic [3:0] fetch_num,
   input wire logic [31:0] fetch_vec,
   input wire logic fetch_valid,
   input wire logic fetch_bad
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_rd_answer: assert property (reg_rd |=> rd_valid) else $error("read not answered");
   a_rd_cause: assert property (rd_valid |-> $past(reg_rd)) else $error("stray read valid");
   a_rd_hold: assert property (!reg_rd |=> $stable(rd_data)) else $error("read data moved");
   a_ctrl_upper: assert property (reg_rd && reg_addr == GIE_CTRL_ADDR |=> rd_data[15:1] == 15'h0)
      else $error("control upper bits set");
   a_hole_zero: assert property (reg_rd && reg_addr == 16'h0cfa |=> rd_data == 16'h0000)
      else $error("unmapped read nonzero");
   // back to back fetches are legal, so each request is judged on its own answer
   a_fetch_answer: assert property (fetch_req |=> fetch_valid)
      else $error("fetch not answered");
   a_fetch_cause: assert property (fetch_valid |-> $past(fetch_req))
      else $error("stray fetch valid");
   a_bad_empty: assert property (fetch_bad |-> fetch_valid && fetch_vec == 32'h0)
      else $error("refused fetch carries vector");
   a_trap_zero: assert property (fetch_req && fetch_trap && fetch_num == 4'h0 |=> fetch_bad)
      else $error("trap zero served");
   a_num_range: assert property (fetch_req && fetch_num > 4'hc |=> fetch_bad)
      else $error("group number above twelve served");
endmodule // gie_sva
bind gie_top gie_sva u_sva (.*);

// ==== verif/gie_top_bench.sv ====
// self-checking bench for the grouped interrupt expander
`timescale 1ns/10ps
module gie_top_bench import gie_pkg::*;;
   logic clk, rst, reg_wr, reg_rd, protected_write_unlock, rd_valid, ctl_en;
   logic fetch_req, fetch_trap, fetch_valid, fetch_bad;
   logic [95:0] req_in;
   logic [15:0] reg_addr, reg_wdata, rd_data;
   logic [11:0] cpu_int;
   logic [3:0] fetch_num;
   logic [31:0] fetch_vec;
   int error_cnt = 0;
   int checks_done = 0;
   gie_top dut (.*);
   gie_cpu_model cpu (.*);
   // free-running system clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic u);
      @(negedge clk);
      {reg_addr, reg_wdata, protected_write_unlock, reg_wr} = {a, d, u, 1'b1};
      @(negedge clk);
      reg_wr = 1'b0;
   endtask
   // valid and data are compared together in the cycle after the strobe
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      @(negedge clk);
      {reg_addr, reg_rd} = {a, 1'b1};
      @(negedge clk);
      reg_rd = 1'b0;
      cmp({15'h0, rd_valid, rd_data}, {16'h0001, exp});
   endtask
   task automatic fet(input logic t, input logic [3:0] n, input logic [31:0] exp, input logic eb);
      logic [31:0] v;
      logic b;
      cpu.fetch(t, n, v, b);
      cmp(v, exp);
      cmp({31'h0, b}, {31'h0, eb});
   endtask
   // bounded wait for one cpu line to reach a level, then judged either way
   task automatic line(input int g, input logic lv);
      for (int i = 0; i < 12 && cpu_int[g] !== lv; i++) begin
         @(negedge clk);
      end
      cmp({31'h0, cpu_int[g]}, {31'h0, lv});
      if (cpu_int[g] !== lv) wrap_up();
   endtask
   task automatic t_reset();
      rd(GIE_CTRL_ADDR, 16'h0000);
      rd(GIE_ACK_ADDR, 16'h0000);
      rd(16'h0ce3, 16'h0000);
      rd(16'h0cfa, 16'h0000);
   endtask
   task automatic t_trap();
      wr(16'h0d44, 16'h1234, 1'b1);
      wr(16'h0d45, 16'h5678, 1'b1);
      wr(16'h0d50, 16'haaaa, 1'b1);
      wr(16'h0d51, 16'h5555, 1'b1);
      wr(16'h0d50, 16'h0bad, 1'b0); // locked write must be dropped
      fet(1'b1, 4'h0, 32'h0, 1'b1); // only while disabled
      wr(GIE_CTRL_ADDR, 16'hffff, 1'b0);
      ctl_en = 1'b1;
      rd(GIE_CTRL_ADDR, 16'h0001);
      fet(1'b1, 4'h2, 32'h5555aaaa, 1'b0);
      fet(1'b1, 4'hd, 32'h0, 1'b1);
      rd(16'h0d50, 16'haaaa); // locked write left the table alone
      rd(16'h0d51, 16'h5555);
   endtask
   task automatic t_irq();
      wr(16'h0ce2, 16'h00ff, 1'b0);
      @(negedge clk);
      req_in[2] = 1'b1;
      line(0, 1'b1);
      fet(1'b0, 4'h1, 32'h56781234, 1'b0);
      rd(GIE_ACK_ADDR, 16'h0001);
      line(0, 1'b0);
      rd(16'h0ce3, 16'h0000);
      fet(1'b0, 4'h1, 32'h0, 1'b1);
      req_in[2] = 1'b0;
      req_in[3] = 1'b1;
      // a new request is flagged but waits behind the pending acknowledge
      repeat (4) @(negedge clk);
      rd(16'h0ce3, 16'h0008);
      line(0, 1'b0);
      wr(GIE_ACK_ADDR, 16'h0001, 1'b0);
      rd(GIE_ACK_ADDR, 16'h0000);
      line(0, 1'b1);
      req_in[3] = 1'b0;
   endtask
   // reset in mid-run: registers return to idle, the table keeps its words
   task automatic t_rerun();
      @(negedge clk);
      rst = 1'b1;
      ctl_en = 1'b0;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      rd(GIE_CTRL_ADDR, 16'h0000);
      rd(GIE_ACK_ADDR, 16'h0000);
      rd(16'h0ce3, 16'h0000);
      rd(16'h0cf0, 16'h0000);
      line(0, 1'b0);
      rd(16'h0d51, 16'h5555);
   endtask
   // reserved slots of group eight used as software interrupts
   task automatic t_soft();
      wr(16'h0cf0, 16'h0080, 1'b0);
      wr(16'h0cf1, 16'h0081, 1'b0);
      line(7, 1'b1);
      rd(16'h0cf1, 16'h0081);
      wr(16'h0cf1, 16'h0001, 1'b0);
      rd(16'h0cf1, 16'h0001);
      line(7, 1'b0);
   endtask
   // main sequence
   initial begin
      {rst, reg_wr, reg_rd, protected_write_unlock, ctl_en} = 5'b10000;
      {req_in, reg_addr, reg_wdata} = '0;
      repeat (5) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_trap();
      t_irq();
      t_soft();
      t_rerun();
      wrap_up();
   end
endmodule // gie_top_bench
